// >>> decode_pkg.sv
package decode_pkg;
	localparam int REG_W = 3;
	localparam int MRM_RM_LSB = 0;
	localparam int MRM_REG_LSB = 3;
	localparam int MRM_MOD_LSB = 6;
	localparam logic [1:0] MOD_REG_FORM = 2'h3;
	localparam int BYTE_W = 8;
	localparam int WORD16_W = 16;
	localparam int WORD32_W = 32;
	localparam int FAR_DISP_W = 48;
	localparam logic [7:0] OP_TWO_BYTE = 8'h0f;
	localparam logic [7:0] OP_GRP_BYTE_IMMEDIATE = 8'h80;
	localparam logic [7:0] OP_GRP_IMMW = 8'h81;
	localparam logic [7:0] OP_GRP_IMMS8 = 8'h83;
	localparam logic [7:0] OP_DAA_ASCII_ADJ = 8'h37;
	localparam logic [7:0] OP_DAS_ASCII_ADJ = 8'h3f;
	localparam logic [7:0] OP_ASCII_MUL = 8'hd4;
	localparam logic [7:0] OP_ASCII_DIV = 8'hd5;
	localparam logic [7:0] OP_BOUND_CHECK = 8'h62;
	localparam logic [7:0] OP_ADJ_PRIV = 8'h63;
	localparam logic [7:0] OP_PUSH_IMMW = 8'h68;
	localparam logic [7:0] OP_JCC_SHORT = 8'h70;
	localparam logic [7:0] OP_JMP_FAR = 8'hea;
	localparam logic [7:0] OP_FP_ESC_LO = 8'hd8;
	localparam logic [7:0] OP_FP_ESC_HI = 8'hdf;
	localparam logic [7:0] OP_MEDIA_LO = 8'h60;
	localparam logic [7:0] OP_MEDIA_HI = 8'h7f;
	localparam logic [7:0] OP_MOV_REG_IMM = 8'hb8;
	localparam logic [7:0] OP_BSWAP_BASE = 8'hc8;
	localparam logic [7:0] OP_BITSCAN_LO = 8'hbc;
	localparam logic [7:0] OP_BITSCAN_HI = 8'hbd;
	localparam int MAX_OPS = 3;

	typedef enum logic [1:0] {DEC_SHORT, DEC_LONG, DEC_VECTOR} dec_kind_e;
	typedef enum logic [3:0] {
		OP_NONE, OP_LOAD, OP_FP_LOAD, OP_MEDIA_LOAD, OP_STORE, OP_FP_STORE,
		OP_MEDIA_STORE, OP_ANY_INT, OP_INT_X, OP_BRANCH, OP_FLOAT, OP_MEDIA_UNIT,
		OP_IMM_LOAD
	} op_kind_e;
	typedef enum logic [2:0] {
		UNIT_NONE, UNIT_LOAD, UNIT_STORE, UNIT_INT_ANY, UNIT_INT_X, UNIT_BRANCH,
		UNIT_FP, UNIT_MEDIA
	} unit_e;
	typedef enum logic [2:0] {U_NONE2, U_ICU} ctl_t_unused_e;

	function automatic unit_e op_unit(input op_kind_e k);
		unit_e u;
		u = UNIT_NONE;
		unique case (k)
			OP_LOAD, OP_FP_LOAD, OP_MEDIA_LOAD: u = UNIT_LOAD;
			OP_STORE, OP_FP_STORE, OP_MEDIA_STORE: u = UNIT_STORE;
			OP_ANY_INT: u = UNIT_INT_ANY;
			OP_INT_X: u = UNIT_INT_X;
			OP_BRANCH: u = UNIT_BRANCH;
			OP_FLOAT: u = UNIT_FP;
			OP_MEDIA_UNIT: u = UNIT_MEDIA;
			OP_NONE, OP_IMM_LOAD: u = UNIT_NONE;
		endcase
		return u;
	endfunction : op_unit
endpackage : decode_pkg

// >>> exec_sched_model.sv
`timescale 1ns/100ps
module exec_sched_model
	import decode_pkg::*;
(
	input wire logic CLK, // core clock
	input wire logic NRST, // async reset, active low
	input wire logic OUT_VALID_A, // slot A decode valid
	input wire unit_e UNIT0_A, // slot A op 0 unit
	input wire unit_e UNIT1_A, // slot A op 1 unit
	input wire unit_e UNIT2_A, // slot A op 2 unit
	output logic INT_X_BUSY // X unit claimed by slot A in the previous cycle (registered)
);
	logic x_busy_r;
	assign INT_X_BUSY = x_busy_r;
	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
			x_busy_r <= 1'b0;
		else
			x_busy_r <= OUT_VALID_A && (UNIT0_A == UNIT_INT_X || UNIT1_A == UNIT_INT_X
				|| UNIT2_A == UNIT_INT_X);
	end
endmodule : exec_sched_model

// >>> insn_classify.sv
`timescale 1ns/100ps
module insn_classify
	import decode_pkg::*;
(
	input wire logic [7:0] opc, // first opcode byte
	input wire logic [7:0] opc2, // second byte after escape
	input wire logic [7:0] modrm, // modR/M byte
	input wire logic opsize32, // operand size 32
	output dec_kind_e kind, // decode class
	output op_kind_e op0, // first internal operation
	output op_kind_e op1, // second internal operation
	output op_kind_e op2, // third internal operation
	output logic has_modrm, // modR/M byte used
	output logic mem_form, // memory-operand variant
	output logic [5:0] imm_bits, // immediate width in bits
	output logic [5:0] disp_bits // extra displacement width in bits
);
	logic is_mem;
	logic byte_op;
	logic arith;
	logic mem_dst;

	assign is_mem = modrm[MRM_MOD_LSB +: 2] != MOD_REG_FORM;

	always_comb
	begin
		kind = DEC_SHORT;
		op0 = OP_NONE;
		op1 = OP_NONE;
		op2 = OP_NONE;
		has_modrm = 1'b0;
		imm_bits = '0;
		disp_bits = '0;
		arith = 1'b0;
		byte_op = 1'b0;
		mem_dst = 1'b0;
		if (opc[7:6] == 2'h0 && opc[2:0] < 3'h6)
		begin
			arith = 1'b1;
			byte_op = ~opc[0];
			has_modrm = ~opc[2];
			mem_dst = ~opc[1] & ~opc[2];
			if (opc[2])
				imm_bits = opc[0] ? (opsize32 ? 6'(WORD32_W) : 6'(WORD16_W)) : 6'(BYTE_W);
		end
		else if (opc == OP_GRP_BYTE_IMMEDIATE || opc == OP_GRP_IMMW || opc == OP_GRP_IMMS8)
		begin
			arith = 1'b1;
			has_modrm = 1'b1;
			mem_dst = 1'b1;
			byte_op = opc != OP_GRP_IMMW;
			imm_bits = (opc == OP_GRP_IMMW) ? (opsize32 ? 6'(WORD32_W) : 6'(WORD16_W))
				: 6'(BYTE_W);
		end
		if (arith)
		begin
			op0 = byte_op ? OP_INT_X : OP_ANY_INT;
			if (has_modrm && is_mem && mem_dst)
			begin
				kind = DEC_LONG;
				op0 = OP_LOAD;
				op1 = byte_op ? OP_INT_X : OP_ANY_INT;
				op2 = OP_STORE;
			end
			else if (has_modrm && is_mem)
			begin
				op0 = OP_LOAD;
				op1 = byte_op ? OP_INT_X : OP_ANY_INT;
			end
		end
		else if (opc == OP_DAA_ASCII_ADJ || opc == OP_DAS_ASCII_ADJ
			|| opc == OP_ASCII_MUL || opc == OP_ASCII_DIV || opc == OP_BOUND_CHECK)
			kind = DEC_VECTOR;
		else if (opc == OP_ADJ_PRIV)
		begin
			kind = DEC_VECTOR;
			has_modrm = 1'b1;
		end
		else if (opc == OP_TWO_BYTE)
		begin
			if (opc2 == OP_BITSCAN_LO || opc2 == OP_BITSCAN_HI)
			begin
				kind = DEC_VECTOR;
				has_modrm = 1'b1;
			end
			else if (opc2[7:3] == OP_BSWAP_BASE[7:3])
			begin
				kind = DEC_LONG;
				op0 = OP_ANY_INT;
			end
			else if (opc2 >= OP_MEDIA_LO && opc2 <= OP_MEDIA_HI)
			begin
				has_modrm = 1'b1;
				op0 = is_mem ? OP_MEDIA_LOAD : OP_MEDIA_UNIT;
				op1 = is_mem ? OP_MEDIA_UNIT : OP_NONE;
			end
			else
				kind = DEC_VECTOR;
		end
		else if (opc >= OP_FP_ESC_LO && opc <= OP_FP_ESC_HI)
		begin
			has_modrm = 1'b1;
			op0 = is_mem ? OP_FP_LOAD : OP_FLOAT;
			op1 = is_mem ? OP_FLOAT : OP_NONE;
			if (is_mem && modrm[MRM_REG_LSB +: REG_W] >= 3'h2 && opc[0])
			begin
				kind = DEC_LONG;
				op1 = OP_FLOAT;
				op2 = OP_FP_STORE;
			end
		end
		else if (opc[7:4] == OP_JCC_SHORT[7:4])
		begin
			op0 = OP_BRANCH;
			disp_bits = 6'(BYTE_W);
		end
		else if (opc == OP_JMP_FAR)
		begin
			kind = DEC_VECTOR;
			disp_bits = 6'(FAR_DISP_W);
		end
		else if (opc[7:3] == OP_MOV_REG_IMM[7:3] || opc == OP_PUSH_IMMW)
		begin
			op0 = OP_IMM_LOAD;
			imm_bits = opsize32 ? 6'(WORD32_W) : 6'(WORD16_W);
		end
		else
			kind = DEC_VECTOR;
		if (has_modrm && modrm[MRM_MOD_LSB +: 2] == 2'h1)
			disp_bits = 6'(BYTE_W);
		else if (has_modrm && modrm[MRM_MOD_LSB +: 2] == 2'h2)
			disp_bits = opsize32 ? 6'(WORD32_W) : 6'(WORD16_W);
	end

	assign mem_form = has_modrm & is_mem;
endmodule : insn_classify

// >>> x86_decode_classifier.sv
`timescale 1ns/100ps
// Functional notes
// - reg operand from opcode byte or modR/M bits 5..3
// - rm register operand from modR/M bits 2..0
// - media registers from modR/M bits 5..3 and 2..0
// - mod values 10b, 01b, 00b mean memory form
// - modR/M byte selects register or memory variant
// - per clock: two short, or one long, or one vector
// - integer, fp and media loads go to load unit
// - integer, fp and media stores go to store unit
// - any-integer ops may issue to either integer unit
// - X-unit ops issue only to integer X unit
// - branch, fp and media ops to their own units
// - immediate loads run in instruction control unit; only slot A flags this (ICU_OP_A), slot B has no control-unit flag
// - byte immediate 8 bits, word immediate 16 or 32
// - displacement 8, 16 or 32 bits, far forms 48
module x86_decode_classifier
	import decode_pkg::*;
(
	input wire logic CLK, // core clock
	input wire logic NRST, // async reset, active low
	input wire logic IN_VALID_A, // slot A instruction present
	input wire logic [7:0] OPC_A, // slot A opcode byte
	input wire logic [7:0] OPC2_A, // slot A second byte
	input wire logic [7:0] MODRM_A, // slot A modR/M byte
	input wire logic IN_VALID_B, // slot B instruction present
	input wire logic [7:0] OPC_B, // slot B opcode byte
	input wire logic [7:0] OPC2_B, // slot B second byte
	input wire logic [7:0] MODRM_B, // slot B modR/M byte
	input wire logic OPSIZE32, // operand size is 32 bits
	input wire logic INT_X_BUSY, // scheduler: X unit taken by slot A in the previous cycle
	output logic TAKE_A, // slot A consumed
	output logic TAKE_B, // slot B consumed
	output logic OUT_VALID_A, // slot A decode valid
	output dec_kind_e KIND_A, // slot A class
	output op_kind_e OP0_A, // slot A op 0
	output op_kind_e OP1_A, // slot A op 1
	output op_kind_e OP2_A, // slot A op 2
	output unit_e UNIT0_A, // slot A op 0 unit
	output unit_e UNIT1_A, // slot A op 1 unit
	output unit_e UNIT2_A, // slot A op 2 unit
	output logic ICU_OP_A, // slot A limm in control unit
	output logic MEM_A, // slot A memory form
	output logic [2:0] REG_A, // slot A reg field register
	output logic [2:0] RM_A, // slot A rm field register
	output logic [5:0] IMM_BITS_A, // slot A immediate width
	output logic [5:0] DISP_BITS_A, // slot A displacement width
	output logic OUT_VALID_B, // slot B decode valid
	output op_kind_e OP0_B, // slot B op 0
	output op_kind_e OP1_B, // slot B op 1
	output unit_e UNIT0_B, // slot B op 0 unit
	output unit_e UNIT1_B, // slot B op 1 unit
	output logic [2:0] REG_B, // slot B reg field register
	output logic [2:0] RM_B, // slot B rm field register
	output logic [5:0] IMM_BITS_B, // slot B immediate width
	output logic [5:0] DISP_BITS_B // slot B displacement width
);
	dec_kind_e kind_a, kind_b;
	op_kind_e a0, a1, a2, b0, b1, b2;
	logic hm_a, hm_b, mf_a, mf_b;
	logic [5:0] ib_a, ib_b, db_a, db_b;
	logic pair_ok;

	insn_classify u_cls_a (
		.opc(OPC_A), .opc2(OPC2_A), .modrm(MODRM_A), .opsize32(OPSIZE32),
		.kind(kind_a), .op0(a0), .op1(a1), .op2(a2), .has_modrm(hm_a),
		.mem_form(mf_a), .imm_bits(ib_a), .disp_bits(db_a)
	);
	insn_classify u_cls_b (
		.opc(OPC_B), .opc2(OPC2_B), .modrm(MODRM_B), .opsize32(OPSIZE32),
		.kind(kind_b), .op0(b0), .op1(b1), .op2(b2), .has_modrm(hm_b),
		.mem_form(mf_b), .imm_bits(ib_b), .disp_bits(db_b)
	);

	// register field extraction; opcode low bits when no modR/M
	function automatic logic [2:0] reg_sel(input logic hm, input logic [7:0] opc,
		input logic [7:0] mrm);
		return hm ? mrm[MRM_REG_LSB +: REG_W] : opc[REG_W-1:0];
	endfunction : reg_sel

	// int unit choice: plain op_unit mapping; INT_X_BUSY is ignored, so X-only ops never wait and any ops never fall over
	function automatic unit_e steer(input op_kind_e k);
		return op_unit(k);
	endfunction : steer

	assign pair_ok = IN_VALID_A && IN_VALID_B && kind_a == DEC_SHORT && kind_b == DEC_SHORT;
	assign TAKE_A = IN_VALID_A;
	assign TAKE_B = pair_ok;

	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			OUT_VALID_A <= 1'b0;
			KIND_A <= DEC_SHORT;
			OP0_A <= OP_NONE;
			OP1_A <= OP_NONE;
			OP2_A <= OP_NONE;
			UNIT0_A <= UNIT_NONE;
			UNIT1_A <= UNIT_NONE;
			UNIT2_A <= UNIT_NONE;
			ICU_OP_A <= 1'b0;
			MEM_A <= 1'b0;
			REG_A <= '0;
			RM_A <= '0;
			IMM_BITS_A <= '0;
			DISP_BITS_A <= '0;
		end
		else
		begin
			OUT_VALID_A <= IN_VALID_A;
			KIND_A <= kind_a;
			OP0_A <= a0;
			OP1_A <= a1;
			OP2_A <= a2;
			UNIT0_A <= steer(a0);
			UNIT1_A <= steer(a1);
			UNIT2_A <= steer(a2);
			ICU_OP_A <= IN_VALID_A && a0 == OP_IMM_LOAD;
			MEM_A <= mf_a;
			REG_A <= reg_sel(hm_a, OPC_A, MODRM_A);
			RM_A <= MODRM_A[MRM_RM_LSB +: REG_W];
			IMM_BITS_A <= ib_a;
			DISP_BITS_A <= db_a;
		end
	end

	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			OUT_VALID_B <= 1'b0;
			OP0_B <= OP_NONE;
			OP1_B <= OP_NONE;
			UNIT0_B <= UNIT_NONE;
			UNIT1_B <= UNIT_NONE;
			REG_B <= '0;
			RM_B <= '0;
			IMM_BITS_B <= '0;
			DISP_BITS_B <= '0;
		end
		else
		begin
			OUT_VALID_B <= pair_ok;
			OP0_B <= b0;
			OP1_B <= b1;
			UNIT0_B <= steer(b0);
			UNIT1_B <= steer(b1);
			REG_B <= reg_sel(hm_b, OPC_B, MODRM_B);
			RM_B <= MODRM_B[MRM_RM_LSB +: REG_W];
			IMM_BITS_B <= ib_b;
			DISP_BITS_B <= db_b;
		end
	end

	// second slot only with short pair
	a_pair_short: assert property (@(posedge CLK) disable iff (!NRST)
		OUT_VALID_B |-> OUT_VALID_A && KIND_A == DEC_SHORT)
		else $error("slot B valid without short pair");
	a_long_alone: assert property (@(posedge CLK) disable iff (!NRST)
		IN_VALID_A && kind_a != DEC_SHORT |-> !TAKE_B)
		else $error("long or vector paired");
	a_load_unit: assert property (@(posedge CLK) disable iff (!NRST)
		(a0 == OP_LOAD || a0 == OP_FP_LOAD || a0 == OP_MEDIA_LOAD) |=> UNIT0_A == UNIT_LOAD)
		else $error("load not routed to load unit");
	a_store_unit: assert property (@(posedge CLK) disable iff (!NRST)
		(a2 == OP_STORE || a2 == OP_FP_STORE) |=> UNIT2_A == UNIT_STORE)
		else $error("store not routed to store unit");
	a_x_only: assert property (@(posedge CLK) disable iff (!NRST)
		OP1_A == OP_INT_X |-> UNIT1_A == UNIT_INT_X)
		else $error("X op sent elsewhere");
	a_any_int: assert property (@(posedge CLK) disable iff (!NRST)
		OP0_A == OP_ANY_INT |-> UNIT0_A == UNIT_INT_ANY)
		else $error("any-int op misrouted");
	a_mem_dst_long: assert property (@(posedge CLK) disable iff (!NRST)
		IN_VALID_A && OPC_A == OP_GRP_BYTE_IMMEDIATE && MODRM_A[7:6] != MOD_REG_FORM
		|=> KIND_A == DEC_LONG && OP0_A == OP_LOAD && OP1_A == OP_INT_X && OP2_A == OP_STORE)
		else $error("memory destination not long");
	a_reg_field: assert property (@(posedge CLK) disable iff (!NRST)
		hm_a |=> REG_A == $past(MODRM_A[5:3]))
		else $error("reg field wrong");
	a_rm_field: assert property (@(posedge CLK) disable iff (!NRST)
		IN_VALID_A |=> RM_A == $past(MODRM_A[2:0]))
		else $error("rm field wrong");
	a_mem_form: assert property (@(posedge CLK) disable iff (!NRST)
		hm_a && MODRM_A[7:6] != MOD_REG_FORM |=> MEM_A)
		else $error("memory form missed");
	a_limm_icu: assert property (@(posedge CLK) disable iff (!NRST)
		IN_VALID_A && OPC_A[7:3] == OP_MOV_REG_IMM[7:3] |=> ICU_OP_A && UNIT0_A == UNIT_NONE)
		else $error("limm not in control unit");

	c_pair: cover property (@(posedge CLK) disable iff (!NRST) OUT_VALID_B);
	c_long: cover property (@(posedge CLK) disable iff (!NRST) OUT_VALID_A && KIND_A == DEC_LONG);
	c_vector: cover property (@(posedge CLK) disable iff (!NRST)
		OUT_VALID_A && KIND_A == DEC_VECTOR);
endmodule : x86_decode_classifier

// >>> x86_decode_classifier_tb.sv
`timescale 1ns/100ps
module x86_decode_classifier_tb;
	import decode_pkg::*;
	logic clk, nrst, va, vb, opsize32, int_x_busy, take_a, take_b, ova, ovb, icu, mem_a;
	logic [7:0] opc_a, opc2_a, modrm_a, opc_b, opc2_b, modrm_b;
	logic [2:0] reg_a, rm_a, reg_b, rm_b;
	logic [5:0] imm_a, disp_a, imm_b, disp_b;
	dec_kind_e kind_a;
	op_kind_e op0_a, op1_a, op2_a, op0_b, op1_b;
	unit_e u0_a, u1_a, u2_a, u0_b, u1_b;
	int failures, comparisons, cycles;
	logic [7:0] vec_opc [8] = '{8'h37, 8'h3f, 8'hd4, 8'hd5, 8'h62, 8'h63, 8'h0f, 8'h0f};
	logic [7:0] vec_opc2 [8] = '{8'h00, 8'h00, 8'h0a, 8'h0a, 8'h00, 8'h00, 8'hbc, 8'hbd};

	x86_decode_classifier x86_decode_classifier_i (.CLK(clk), .NRST(nrst),
		.IN_VALID_A(va), .OPC_A(opc_a), .OPC2_A(opc2_a), .MODRM_A(modrm_a),
		.IN_VALID_B(vb), .OPC_B(opc_b), .OPC2_B(opc2_b), .MODRM_B(modrm_b),
		.OPSIZE32(opsize32), .INT_X_BUSY(int_x_busy), .TAKE_A(take_a), .TAKE_B(take_b),
		.OUT_VALID_A(ova), .KIND_A(kind_a), .OP0_A(op0_a), .OP1_A(op1_a), .OP2_A(op2_a),
		.UNIT0_A(u0_a), .UNIT1_A(u1_a), .UNIT2_A(u2_a), .ICU_OP_A(icu), .MEM_A(mem_a),
		.REG_A(reg_a), .RM_A(rm_a), .IMM_BITS_A(imm_a), .DISP_BITS_A(disp_a),
		.OUT_VALID_B(ovb), .OP0_B(op0_b), .OP1_B(op1_b), .UNIT0_B(u0_b), .UNIT1_B(u1_b),
		.REG_B(reg_b), .RM_B(rm_b), .IMM_BITS_B(imm_b), .DISP_BITS_B(disp_b));
	exec_sched_model exec_sched_model_i (.CLK(clk), .NRST(nrst), .OUT_VALID_A(ova),
		.UNIT0_A(u0_a), .UNIT1_A(u1_a), .UNIT2_A(u2_a), .INT_X_BUSY(int_x_busy));

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic test_done;
		if (failures == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			failures++;
			$display("MISMATCH t=%0t run did not finish", $time);
			test_done();
		end
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			failures++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// drive both slots at an edge, leaving the take flags settled
	task automatic run(input logic a, input logic [7:0] o, o2, m, input logic b,
		input logic [7:0] ob, mb);
		@(posedge clk);
		va <= a;
		opc_a <= o;
		opc2_a <= o2;
		modrm_a <= m;
		vb <= b;
		opc_b <= ob;
		modrm_b <= mb;
		#1;
	endtask : run

	task automatic settle;
		@(posedge clk);
		#1;
	endtask : settle

	task automatic exp_a(input logic [7:0] k, o0, o1, o2);
		check(ova, 8'h01);
		check(kind_a, k);
		check(op0_a, o0);
		check(op1_a, o1);
		check(op2_a, o2);
	endtask : exp_a

	task automatic t_mem_dest;
		for (int m = 0; m < 3; m++)
		begin
			opsize32 <= 1'b1;
			run(1'b1, 8'h80, 8'h00, {m[1:0], 6'h00}, 1'b1, 8'h01, 8'hc0);
			check(take_b, 8'h00);
			settle();
			exp_a(DEC_LONG, OP_LOAD, OP_INT_X, OP_STORE);
			check(u0_a, UNIT_LOAD);
			check(u1_a, UNIT_INT_X);
			check(u2_a, UNIT_STORE);
			check(mem_a, 8'h01);
			check(imm_a, 8'h08);
			check(ovb, 8'h00);
			if (m == 1)
				check(disp_a, 8'h08);
		end
		for (int s = 0; s < 2; s++)
		begin
			opsize32 <= s[0];
			run(1'b1, 8'h81, 8'h00, 8'h08, 1'b0, 8'h00, 8'h00);
			settle();
			exp_a(DEC_LONG, OP_LOAD, OP_ANY_INT, OP_STORE);
			check(u1_a, UNIT_INT_ANY);
			check(imm_a, s ? 8'h20 : 8'h10);
		end
	endtask : t_mem_dest

	task automatic t_short_pairs;
		run(1'b1, 8'h01, 8'h00, 8'hd1, 1'b1, 8'h00, 8'he5);
		check(take_a, 8'h01);
		check(take_b, 8'h01);
		settle();
		exp_a(DEC_SHORT, OP_ANY_INT, OP_NONE, OP_NONE);
		check(mem_a, 8'h00);
		check(reg_a, 8'h02);
		check(rm_a, 8'h01);
		check(ovb, 8'h01);
		check(reg_b, 8'h04);
		check(rm_b, 8'h05);
		check(op0_b, OP_INT_X);
		check(u0_b, UNIT_INT_X);
		run(1'b1, 8'h03, 8'h00, 8'h5a, 1'b1, 8'h02, 8'h40);
		check(take_b, 8'h01);
		settle();
		exp_a(DEC_SHORT, OP_LOAD, OP_ANY_INT, OP_NONE);
		check(mem_a, 8'h01);
		check(reg_a, 8'h03);
		check(rm_a, 8'h02);
		check(op0_b, OP_LOAD);
		check(op1_b, OP_INT_X);
		check(u0_b, UNIT_LOAD);
		check(u1_b, UNIT_INT_X);
		check(disp_b, 8'h08);
		check(imm_b, 8'h00);
		run(1'b1, 8'h05, 8'h00, 8'h00, 1'b1, 8'h04, 8'h00);
		check(take_b, 8'h01);
		settle();
		check(imm_a, 8'h20);
		check(imm_b, 8'h08);
		check(disp_b, 8'h00);
		check(ovb, 8'h01);
	endtask : t_short_pairs

	task automatic t_vector;
		for (int i = 0; i < 8; i++)
		begin
			run(1'b1, vec_opc[i], vec_opc2[i], 8'hc0, 1'b1, 8'h01, 8'hc0);
			check(take_b, 8'h00);
			settle();
			exp_a(DEC_VECTOR, OP_NONE, OP_NONE, OP_NONE);
			check(ovb, 8'h00);
		end
	endtask : t_vector

	task automatic t_units;
		opsize32 <= 1'b1;
		run(1'b1, 8'hbb, 8'h00, 8'h00, 1'b0, 8'h00, 8'h00);
		settle();
		check(icu, 8'h01);
		check(op0_a, OP_IMM_LOAD);
		check(u0_a, UNIT_NONE);
		check(reg_a, 8'h03);
		check(imm_a, 8'h20);
		run(1'b1, 8'h70, 8'h00, 8'h00, 1'b0, 8'h00, 8'h00);
		settle();
		check(u0_a, UNIT_BRANCH);
		check(disp_a, 8'h08);
		run(1'b1, 8'hea, 8'h00, 8'h00, 1'b0, 8'h00, 8'h00);
		settle();
		check(kind_a, DEC_VECTOR);
		check(disp_a, 8'h30);
		run(1'b1, 8'h0f, 8'hc9, 8'h00, 1'b1, 8'h01, 8'hc0);
		check(take_b, 8'h00);
		settle();
		check(kind_a, DEC_LONG);
		run(1'b1, 8'h0f, 8'h60, 8'he9, 1'b0, 8'h00, 8'h00);
		settle();
		check(reg_a, 8'h05);
		check(rm_a, 8'h01);
		check(u0_a, UNIT_MEDIA);
		run(1'b1, 8'h0f, 8'h6f, 8'h08, 1'b0, 8'h00, 8'h00);
		settle();
		check(op0_a, OP_MEDIA_LOAD);
		check(u0_a, UNIT_LOAD);
		run(1'b1, 8'hd8, 8'h00, 8'hc0, 1'b0, 8'h00, 8'h00);
		settle();
		check(u0_a, UNIT_FP);
		run(1'b1, 8'hd9, 8'h00, 8'h10, 1'b0, 8'h00, 8'h00);
		settle();
		check(kind_a, DEC_LONG);
		check(op0_a === OP_FP_STORE || op1_a === OP_FP_STORE || op2_a === OP_FP_STORE,
			8'h01);
		run(1'b0, 8'h00, 8'h00, 8'h00, 1'b0, 8'h00, 8'h00);
		settle();
		check(ova, 8'h00);
	endtask : t_units

	initial
	begin
		failures = 0;
		comparisons = 0;
		cycles = 0;
		nrst = 1'b0;
		va = 1'b0;
		vb = 1'b0;
		opc_a = 8'h00;
		opc2_a = 8'h00;
		modrm_a = 8'h00;
		opc_b = 8'h00;
		opc2_b = 8'h00;
		modrm_b = 8'h00;
		opsize32 = 1'b1;
		repeat (8) @(posedge clk);
		check(ova, 8'h00);
		check(kind_a, DEC_SHORT);
		nrst <= 1'b1;
		t_mem_dest();
		t_short_pairs();
		t_vector();
		t_units();
		test_done();
	end
endmodule : x86_decode_classifier_tb
